// [rtl/ccs_flag_if.sv]
// carrier between the top and the sticky event flag pair
// assumes both ends share ref_clk_in
`default_nettype none

interface ccs_flag_if;
    logic set_burst;
    logic set_update;
    logic clr_burst;
    logic clr_update;
    logic burst_flag;
    logic update_flag;

    modport ctrl (
        output set_burst, set_update, clr_burst, clr_update,
        input  burst_flag, update_flag
    );
    modport flags (
        input  set_burst, set_update, clr_burst, clr_update,
        output burst_flag, update_flag
    );
endinterface : ccs_flag_if

`default_nettype wire

// [rtl/ccs_flags.sv]
// sticky burst-complete and conversion-update flags
// assumes set and clear strobes are one-cycle pulses on ref_clk_in
`default_nettype none

module ccs_flags (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // strobes and flags
    ccs_flag_if.flags fl
);

    logic burst_reg;
    logic update_reg;

    // set beats clear so a completion in the clear cycle survives
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            burst_reg <= 1'b0;
        end else if (fl.set_burst) begin
            burst_reg <= 1'b1;
        end else if (fl.clr_burst) begin
            burst_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            update_reg <= 1'b0;
        end else if (fl.set_update) begin
            update_reg <= 1'b1;
        end else if (fl.clr_update) begin
            update_reg <= 1'b0;
        end
    end

    assign fl.burst_flag  = burst_reg;
    assign fl.update_flag = update_reg;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_set_beats_clear: assert property (
        (fl.set_update && fl.clr_update) |=> update_reg)
        else $error("update flag lost on simultaneous clear");

    a_clear_drops: assert property (
        (fl.clr_burst && !fl.set_burst) |=> !burst_reg)
        else $error("burst flag not cleared");

endmodule : ccs_flags

`default_nettype wire

// [rtl/ccs_pkg.sv]
// converter status and raw result: shared constants
// assumes a 32-bit apb slave with byte addresses, one word per register
`default_nettype none

package ccs_pkg;

    // register byte addresses
    localparam logic [11:0] ADDR_RAW    = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CLEAR  = 12'h008;
    localparam logic [11:0] ADDR_CTRL   = 12'h00C;
    localparam logic [11:0] ADDR_LIMIT0 = 12'h010;
    localparam logic [11:0] ADDR_STEP   = 12'h004;

    // field widths and counts
    localparam int RAW_W     = 24;
    localparam int CONV_W    = 18;
    localparam int SIGN_LSB  = 18;
    localparam int TEMP_W    = 16;
    localparam int ALERT_CNT = 4;

    // status bit positions
    localparam int STAT_BURST  = 7;
    localparam int STAT_UPDATE = 6;
    localparam int STAT_SHORT  = 5;
    localparam int STAT_RANGE  = 4;

    // reset values
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [23:0] RAW_RST    = 24'h000000;
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [15:0] LIMIT_RST  = 16'h0000;

endpackage : ccs_pkg

`default_nettype wire

// [rtl/ccs_top.sv]
// converter status and raw result register bank with apb access
// assumes converter strobes are one-cycle pulses synchronous to ref_clk_in
//
// What this block does
// - raw result is 24-bit sign-extended, read-only
// - burst end sets status bit 7
// - writing zero to bits 7,6 changes nothing
// - each conversion sets status bit 6
// - bit 5 shows a shorted sensor wire
// - bit 4 shows input or hot result overrange
// - overrange voltage holds hot and difference results
// - status reports single and burst update state
// - bits 7,6 cleared by a one in the clear register, rest read-only, reset zero
// - overrange sum holds only the hot result
// - bits 3-0 flag temperature above alert limit
//
// The address map and the APB register port are this design's own decisions.
`default_nettype none

module ccs_top #(
    parameter bit FAULT_DETECT = 1'b1
) (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // apb slave
    input  wire logic [11:0] paddr_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // converter events and data
    input  wire logic        conv_done_in,
    input  wire logic        burst_done_in,
    input  wire logic [17:0] conv_result_in,
    input  wire logic        sensor_voltage_oor_in,
    input  wire logic        sum_oor_in,
    input  wire logic        hot_result_oor_in,
    input  wire logic        wire_short_in,
    // junction temperatures for the alert compare
    input  wire logic [15:0] hot_temp_in,
    input  wire logic [15:0] cold_temp_in,
    // result register update strobes
    output logic             hot_update_out,
    output logic             diff_update_out,
    output logic             cold_update_out
);

    // carrier to the sticky flag pair
    ccs_flag_if fl ();

    ccs_flags u_flags (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .fl         (fl.flags)
    );

    // state
    logic [23:0] raw_reg;
    logic        short_reg;
    logic        range_reg;
    logic [3:0]  ctrl_reg;
    logic [3:0]  alert_reg;
    logic [31:0] rdata_next;
    logic        hit_next;
    logic [7:0]  status_w;
    logic [15:0] limit_w [ccs_pkg::ALERT_CNT];

    // apb phases
    logic setup_w;
    logic wr_w;

    assign setup_w = psel_in && !penable_in;
    // a write lands at the single access edge where pready is high
    assign wr_w    = psel_in && penable_in && pready_out && pwrite_in;

    // status word as software sees it
    assign status_w = {fl.burst_flag,
                       fl.update_flag,
                       short_reg,
                       range_reg,
                       alert_reg};

    // ---------------------------------------------------------------
    // converter side
    // ---------------------------------------------------------------

    // raw result sign-extended from the converter's 18 bits
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            raw_reg <= ccs_pkg::RAW_RST;
        end else if (conv_done_in) begin
            raw_reg <= {{(ccs_pkg::RAW_W - ccs_pkg::SIGN_LSB)
                         {conv_result_in[ccs_pkg::CONV_W-1]}},
                        conv_result_in};
        end
    end

    // flag set strobes come straight from the converter events
    assign fl.set_burst  = burst_done_in;
    assign fl.set_update = conv_done_in;

    // short flag only exists on the fault-detect variant
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            short_reg <= 1'b0;
        end else if (FAULT_DETECT) begin
            short_reg <= wire_short_in;
        end else begin
            short_reg <= 1'b0;
        end
    end

    // range flag follows the live voltage and hot-result range checks
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            range_reg <= 1'b0;
        end else begin
            range_reg <= sensor_voltage_oor_in
                       | hot_result_oor_in;
        end
    end

    // result update gating: cold always, others held on overrange
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hot_update_out  <= 1'b0;
            diff_update_out <= 1'b0;
            cold_update_out <= 1'b0;
        end else begin
            cold_update_out <= conv_done_in;
            diff_update_out <= conv_done_in
                             && !sensor_voltage_oor_in;
            hot_update_out  <= conv_done_in
                             && !sensor_voltage_oor_in
                             && !sum_oor_in;
        end
    end

    // ---------------------------------------------------------------
    // alert compare, one comparator and limit per channel
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < ccs_pkg::ALERT_CNT; g++) begin : g_alert
            localparam logic [11:0] ADDR_LIM =
                12'(ccs_pkg::ADDR_LIMIT0 + g * ccs_pkg::ADDR_STEP);
            logic [15:0] limit_reg;
            logic [15:0] temp_w;

            // ctrl bit picks cold junction, else hot junction
            assign temp_w = ctrl_reg[g] ? cold_temp_in : hot_temp_in;

            // limit written lane by lane
            always_ff @(posedge ref_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    limit_reg <= ccs_pkg::LIMIT_RST;
                end else if (wr_w && paddr_in == ADDR_LIM) begin
                    if (pstrb_in[0]) begin
                        limit_reg[7:0] <= pwdata_in[7:0];
                    end
                    if (pstrb_in[1]) begin
                        limit_reg[15:8] <= pwdata_in[15:8];
                    end
                end
            end

            // strictly above the limit; equal reads as clear
            always_ff @(posedge ref_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    alert_reg[g] <= 1'b0;
                end else begin
                    alert_reg[g] <= $signed(temp_w)
                                  > $signed(limit_reg);
                end
            end

            assign limit_w[g] = limit_reg;
        end
    endgenerate

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------

    // control: alert source select per channel
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg <= ccs_pkg::CTRL_RST;
        end else if (wr_w && paddr_in == ccs_pkg::ADDR_CTRL
                     && pstrb_in[0]) begin
            ctrl_reg <= pwdata_in[3:0];
        end
    end

    // only a one in the clear register drops a flag; a zero written
    // to the status word itself never does
    assign fl.clr_burst  = wr_w && paddr_in == ccs_pkg::ADDR_CLEAR
                         && pstrb_in[0]
                         && pwdata_in[ccs_pkg::STAT_BURST];
    assign fl.clr_update = wr_w && paddr_in == ccs_pkg::ADDR_CLEAR
                         && pstrb_in[0]
                         && pwdata_in[ccs_pkg::STAT_UPDATE];

    // ---------------------------------------------------------------
    // apb read mux and answer
    // ---------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h00000000;
        hit_next   = 1'b1;
        case (paddr_in)
            ccs_pkg::ADDR_RAW: begin
                rdata_next[23:0] = raw_reg;
            end
            ccs_pkg::ADDR_STATUS: begin
                rdata_next[7:0] = status_w;
            end
            ccs_pkg::ADDR_CLEAR: begin
                rdata_next = 32'h00000000;
            end
            ccs_pkg::ADDR_CTRL: begin
                rdata_next[3:0] = ctrl_reg;
            end
            default: begin
                hit_next = 1'b0;
                for (int i = 0; i < ccs_pkg::ALERT_CNT; i++) begin
                    if (paddr_in == 12'(ccs_pkg::ADDR_LIMIT0
                                   + i * ccs_pkg::ADDR_STEP)) begin
                        rdata_next[15:0] = limit_w[i];
                        hit_next         = 1'b1;
                    end
                end
            end
        endcase
    end

    // zero-wait answer: data and ready registered in the setup cycle
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h00000000;
            pslverr_out <= 1'b0;
        end else if (setup_w) begin
            pready_out  <= 1'b1;
            prdata_out  <= pwrite_in ? 32'h00000000 : rdata_next;
            // status and raw words take no data, but writing them
            // is harmless rather than an error
            pslverr_out <= !hit_next;
        end else begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h00000000;
            pslverr_out <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_setup;
        psel_in && !penable_in;
    endsequence

    sequence s_status_write;
        wr_w && paddr_in == ccs_pkg::ADDR_STATUS;
    endsequence

    a_apb_ready: assert property (
        s_setup ##1 (psel_in && penable_in) |-> pready_out)
        else $error("no ready in first access cycle");

    a_raw_sign: assert property (
        conv_done_in |=> raw_reg[23:18]
                         == {6{$past(conv_result_in[17])}})
        else $error("raw result sign bits wrong");

    a_burst_set: assert property (
        burst_done_in |=> fl.burst_flag [*1] ##0 status_w[7])
        else $error("burst flag not set");

    a_zero_keeps: assert property (
        (s_status_write and fl.update_flag) |=> fl.update_flag)
        else $error("status write dropped update flag");

    a_update_set: assert property (
        conv_done_in |=> status_w[6])
        else $error("update flag not set");

    a_short_gone: assert property (
        !FAULT_DETECT |-> !status_w[5])
        else $error("short bit set on plain variant");

    a_range_flag: assert property (
        (sensor_voltage_oor_in || hot_result_oor_in) |=> status_w[4])
        else $error("range flag missed");

    a_hold_hot: assert property (
        (conv_done_in && sensor_voltage_oor_in)
        |=> cold_update_out && !diff_update_out && !hot_update_out)
        else $error("gating on voltage overrange wrong");

    a_hold_sum: assert property (
        (conv_done_in && !sensor_voltage_oor_in && sum_oor_in)
        |=> diff_update_out && !hot_update_out)
        else $error("gating on sum overrange wrong");

    a_alert_cmp: assert property (
        $signed(hot_temp_in) > $signed(limit_w[3]) && !ctrl_reg[3]
        |=> alert_reg[3])
        else $error("alert 3 missed");

    a_alert_eq: assert property (
        $signed(hot_temp_in) <= $signed(limit_w[0]) && !ctrl_reg[0]
        |=> !alert_reg[0])
        else $error("alert 0 set at or below limit");

    a_range_clear: assert property (
        !(sensor_voltage_oor_in || hot_result_oor_in) |=> !status_w[4])
        else $error("range flag set while in range");

    a_short_track: assert property (
        (FAULT_DETECT && wire_short_in) |=> status_w[5])
        else $error("short flag missed");

    a_burst_keeps: assert property (
        (s_status_write and fl.burst_flag) |=> fl.burst_flag)
        else $error("status write dropped burst flag");

    a_clear_win: assert property (
        (conv_done_in && fl.clr_update) |=> ##1 $past(status_w[6]))
        else $error("completion lost under clear");

endmodule : ccs_top

`default_nettype wire

// [tb/ccs_host_model.sv]
// host-side apb master model for the converter status register bank
// assumes the slave answers on ref_clk_in and the top module is named tb
`default_nettype none

module ccs_host_model (
    // clock
    input  wire logic        ref_clk_in,
    // apb master side
    output logic [11:0]      paddr_out,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic [31:0]      pwdata_out,
    output logic [3:0]       pstrb_out,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // bus idle at time zero, all lanes always enabled
    initial begin
        paddr_out   = 12'h000;
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        pwdata_out  = 32'h00000000;
        pstrb_out   = 4'hF;
    end

    // one transfer; pready, read data and error are all taken at the
    // rising edge that completes the access, and only then is it released
    task automatic xfer(input logic wr, input logic [11:0] addr,
                        input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        int n;
        @(posedge ref_clk_in);
        paddr_out   <= addr;
        pwrite_out  <= wr;
        pwdata_out  <= wdata;
        psel_out    <= 1'b1;
        penable_out <= 1'b0;
        @(posedge ref_clk_in);
        penable_out <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 50);
        if (n >= 50) begin
            tb.bad_count++;
            tb.final_report();
        end
        rdata = prdata_in;
        err   = pslverr_in;
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        // released data must not keep looking valid
        pwdata_out  <= ~wdata;
    endtask : xfer

    // clear a flag, then poll status until the device raises it again
    task automatic clear_and_poll(input logic [7:0] mask,
                                  output logic [7:0] first_rd,
                                  output logic [7:0] last_rd);
        logic [31:0] d;
        logic        e;
        int          n;
        xfer(1'b1, ccs_pkg::ADDR_CLEAR, {24'h000000, mask}, d, e);
        xfer(1'b0, ccs_pkg::ADDR_STATUS, 32'h00000000, d, e);
        first_rd = d[7:0];
        n = 0;
        while ((d[7:0] & mask) == 8'h00 && n < 40) begin
            xfer(1'b0, ccs_pkg::ADDR_STATUS, 32'h00000000, d, e);
            n++;
        end
        if (n >= 40) begin
            tb.bad_count++;
            tb.final_report();
        end
        last_rd = d[7:0];
    endtask : clear_and_poll

endmodule : ccs_host_model

`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the converter status and raw result bank
// assumes ccs_pkg, ccs_flag_if, ccs_flags and ccs_top are compiled first
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk_in, rst_in, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, prdata2, rd;
    logic [3:0]  pstrb;
    logic        pready, pready2, pslverr, conv_done, burst_done;
    logic [17:0] conv_result;
    logic        sv_oor, sum_oor, hot_oor, wire_short;
    logic [15:0] hot_temp, cold_temp;
    logic        hot_upd, diff_upd, cold_upd;
    logic [2:0]  upd;
    logic [7:0]  st2, first_rd, last_rd;
    int          bad_count = 0;
    int          total_checks = 0;

    // 10 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    ccs_host_model host (.ref_clk_in(ref_clk_in), .paddr_out(paddr),
        .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .pwdata_out(pwdata), .pstrb_out(pstrb), .prdata_in(prdata),
        .pready_in(pready), .pslverr_in(pslverr));

    ccs_top #(.FAULT_DETECT(1'b1)) dut (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .conv_done_in(conv_done),
        .burst_done_in(burst_done), .conv_result_in(conv_result),
        .sensor_voltage_oor_in(sv_oor), .sum_oor_in(sum_oor),
        .hot_result_oor_in(hot_oor), .wire_short_in(wire_short),
        .hot_temp_in(hot_temp), .cold_temp_in(cold_temp),
        .hot_update_out(hot_upd), .diff_update_out(diff_upd),
        .cold_update_out(cold_upd));

    // variant without fault detection shares every input
    ccs_top #(.FAULT_DETECT(1'b0)) dut_nofault (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata2), .pready_out(pready2),
        .pslverr_out(), .conv_done_in(conv_done),
        .burst_done_in(burst_done), .conv_result_in(conv_result),
        .sensor_voltage_oor_in(sv_oor), .sum_oor_in(sum_oor),
        .hot_result_oor_in(hot_oor), .wire_short_in(wire_short),
        .hot_temp_in(hot_temp), .cold_temp_in(cold_temp),
        .hot_update_out(), .diff_update_out(), .cold_update_out());

    // second device's status captured while its answer stands
    always @(negedge ref_clk_in) if (pready2 === 1'b1) st2 <= prdata2[7:0];

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd_reg(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h00000000, rd, err);
    endtask : rd_reg

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
    endtask : wr_reg

    task automatic st_is(input string what, input logic [7:0] exp);
        rd_reg(ccs_pkg::ADDR_STATUS);
        check(what, rd, {24'h000000, exp});
    endtask : st_is

    // one conversion pulse; update strobes caught in the following cycle
    task automatic conv(input logic [17:0] r, input logic v, input logic s);
        @(posedge ref_clk_in);
        conv_done   <= 1'b1;
        conv_result <= r;
        sv_oor      <= v;
        sum_oor     <= s;
        @(posedge ref_clk_in);
        conv_done <= 1'b0;
        @(negedge ref_clk_in);
        upd = {hot_upd, diff_upd, cold_upd};
    endtask : conv

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask : end_test

    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        rst_in = 1'b1;
        {conv_done, burst_done, sv_oor, sum_oor, hot_oor, wire_short} = 6'h00;
        conv_result = 18'h00000;
        hot_temp    = 16'h0000;
        cold_temp   = 16'h0000;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        st_is("status reset", 8'h00);
        rd_reg(ccs_pkg::ADDR_RAW);
        check("raw reset", rd, 32'h00000000);
        end_test("reset");
        // negative then positive result, raw is read-only
        conv(18'h20001, 1'b0, 1'b0);
        check("pulses in range", {29'h0, upd}, 32'h00000007);
        wr_reg(ccs_pkg::ADDR_RAW, 32'h00001234);
        rd_reg(ccs_pkg::ADDR_RAW);
        check("raw negative", rd, 32'h00FE0001);
        conv(18'h1FFFF, 1'b0, 1'b0);
        rd_reg(ccs_pkg::ADDR_RAW);
        check("raw positive", rd, 32'h0001FFFF);
        end_test("raw");
        st_is("update set", 8'h40);
        wr_reg(ccs_pkg::ADDR_STATUS, 32'h00000000);
        wr_reg(ccs_pkg::ADDR_CLEAR, 32'h00000000);
        st_is("zero write", 8'h40);
        wr_reg(ccs_pkg::ADDR_STATUS, 32'h000000FF);
        st_is("status ro", 8'h40);
        wr_reg(ccs_pkg::ADDR_CLEAR, 32'h00000040);
        st_is("update clear", 8'h00);
        end_test("update flag");
        // burst flag: cleared, then polled until a burst raises it
        fork
            host.clear_and_poll(8'h80, first_rd, last_rd);
            begin
                repeat (20) @(posedge ref_clk_in);
                burst_done <= 1'b1;
                @(posedge ref_clk_in);
                burst_done <= 1'b0;
            end
        join
        check("poll first", {24'h0, first_rd}, 32'h00000000);
        check("poll last", {24'h0, last_rd}, 32'h00000080);
        wr_reg(ccs_pkg::ADDR_STATUS, 32'h00000000);
        st_is("burst zero write", 8'h80);
        end_test("burst");
        // clears land on the same edge as new events
        fork
            wr_reg(ccs_pkg::ADDR_CLEAR, 32'h000000C0);
            begin
                repeat (2) @(posedge ref_clk_in);
                conv_done  <= 1'b1;
                burst_done <= 1'b1;
                @(posedge ref_clk_in);
                conv_done  <= 1'b0;
                burst_done <= 1'b0;
            end
        join
        st_is("set wins", 8'hC0);
        wr_reg(ccs_pkg::ADDR_CLEAR, 32'h000000C0);
        st_is("both clear", 8'h00);
        end_test("set priority");
        conv(18'h00100, 1'b1, 1'b0);
        check("pulses emf oor", {29'h0, upd}, 32'h00000001);
        st_is("range emf", 8'h50);
        conv(18'h00100, 1'b0, 1'b1);
        check("pulses sum oor", {29'h0, upd}, 32'h00000003);
        wr_reg(ccs_pkg::ADDR_CLEAR, 32'h00000040);
        st_is("sum not range", 8'h00);
        hot_oor <= 1'b1;
        st_is("range hot", 8'h10);
        hot_oor    <= 1'b0;
        wire_short <= 1'b1;
        st_is("short set", 8'h20);
        check("short absent", {24'h0, st2}, 32'h00000000);
        wire_short <= 1'b0;
        st_is("short gone", 8'h00);
        end_test("range and short");
        for (int i = 0; i < 4; i++) begin
            wr_reg(ccs_pkg::ADDR_LIMIT0 + ccs_pkg::ADDR_STEP * 12'(i),
                   (i == 3) ? 32'h0000FFE0 : 32'h00000010);
        end
        hot_temp  <= 16'h0010;
        cold_temp <= 16'h0011;
        st_is("alerts hot", 8'h08);
        wr_reg(ccs_pkg::ADDR_CTRL, 32'h00000005);
        st_is("alerts mixed", 8'h0D);
        end_test("alerts");
        rd_reg(12'h020);
        check("unmapped err", {31'h0, err}, 32'h00000001);
        check("unmapped data", rd, 32'h00000000);
        end_test("unmapped");
        final_report();
    end

endmodule : tb

`default_nettype wire
